// >>> rtl/mise_core.sv
`timescale 1ns/100ps

module mise_core
   import mise_pkg::*;
#(
   parameter int PC_W        = 9,
   parameter int STACK_DEPTH = 2,
   parameter int WDT_PRE_W   = 8,
   parameter int WDT_CNT_W   = 8
)
(
   input  wire logic               CLK,
   input  wire logic               RESET,
   input  wire logic [INSTR_W-1:0] INSTR,
   input  wire logic               INSTR_VALID,
   input  wire logic               WAKE_PIN,
   input  wire logic               STACK_PUSH,
   input  wire logic [PC_W-1:0]    STACK_PUSH_ADDR,
   input  wire logic [BUS_AW-1:0]  BUS_ADDR,
   input  wire logic [DATA_W-1:0]  BUS_WDATA,
   input  wire logic               BUS_WR,
   input  wire logic               BUS_RD,
   output logic      [DATA_W-1:0]  BUS_RDATA,
   output logic                    INSTR_READY,
   output logic      [PC_W-1:0]    PC_OUT,
   output logic      [DATA_W-1:0]  ACC_OUT,
   output logic      [DATA_W-1:0]  OPTION_OUT,
   output mise_flags_s             FLAGS_OUT,
   output logic                    SLEEPING,
   output logic                    OSC_EN
);

   // ==========================================================
   // storage
   logic        [DATA_W-1:0] file_mem [FILE_DEPTH];
   logic        [PC_W-1:0]   stack_r  [STACK_DEPTH];
   logic        [PC_W-1:0]   pc_r;
   logic        [DATA_W-1:0] acc_r;
   logic        [DATA_W-1:0] option_r;
   mise_flags_s              flags_r;
   mise_state_e              state_r;
   mise_state_e              state_nxt;
   logic                     ready_r;
   logic                     sleeping_r;
   logic                     osc_en_r;
   logic        [DATA_W-1:0] rd_data_r;

   // ==========================================================
   // decode
   logic                 take, is_or, is_store, is_copy, is_loadlit;
   logic                 is_retlit, is_nop, is_option, is_sleep;
   logic [FADDR_W-1:0]   f_addr;
   logic                 dest, alu_op, wr_acc_alu, wr_file;
   logic [DATA_W-1:0]    lit, file_rd, alu_res, wr_data;
   logic [PC_W-1:0]      stack_top;
   logic                 wake_evt, wake_clear, bus_wr_file, wdt_ovf;
   logic [2*DATA_W-1:0]  pc_wide;
   logic [WDT_CNT_W-1:0] wdt_cnt;
   logic [WDT_PRE_W-1:0] wdt_pre;

   generate
      if (PC_W < 1 || PC_W > 2 * DATA_W || STACK_DEPTH < 1)
      begin : g_bad
         $error("program counter or stack size out of range");
      end
   endgenerate

   assign take       = INSTR_VALID && (state_r == ST_EXEC);
   assign is_or      = take && ((INSTR & OP_OR_MASK) == OP_OR_VAL);
   assign is_store   = take && ((INSTR & OP_STORE_MASK) == OP_STORE_VAL);
   assign is_copy    = take && ((INSTR & OP_COPY_MASK) == OP_COPY_VAL);
   assign is_loadlit = take && ((INSTR & OP_LIT_MASK) == OP_LOADLIT_VAL);
   assign is_retlit  = take && ((INSTR & OP_LIT_MASK) == OP_RETLIT_VAL);
   assign is_nop     = take && (INSTR == OP_NOP_VAL);
   assign is_option  = take && (INSTR == OP_OPTION_VAL);
   assign is_sleep   = take && (INSTR == OP_SLEEP_VAL);

   assign f_addr  = INSTR[FADDR_W-1:0];
   assign dest    = INSTR[DEST_BIT];
   assign lit     = INSTR[DATA_W-1:0];
   assign file_rd = file_mem[f_addr];
   assign alu_op  = is_or || is_copy;

   assign alu_res = is_or ? (acc_r | file_rd) : file_rd;

   assign wr_acc_alu = alu_op && (dest == DEST_ACC);
   assign wr_file    = (alu_op && (dest == DEST_FILE)) || is_store;
   assign wr_data    = is_store ? acc_r : alu_res;

   assign stack_top   = stack_r[0];
   assign wake_evt    = WAKE_PIN || wdt_ovf;
   assign wake_clear  = BUS_WR && (BUS_ADDR == ADDR_FLAGS) && BUS_WDATA[FLAG_WAKE_BIT];
   assign bus_wr_file = BUS_WR && !BUS_ADDR[FILE_SEL_BIT];
   assign pc_wide     = (2 * DATA_W)'(pc_r);

   // ==========================================================
   // file registers, instruction write wins over the port
   genvar gi;
   generate
      for (gi = 0; gi < FILE_DEPTH; gi++)
      begin : g_file
         always_ff @(posedge CLK)
         begin
            if (RESET)
               file_mem[gi] <= FILE_RST;
            else if (wr_file && (f_addr == FADDR_W'(gi)))
               file_mem[gi] <= wr_data;
            else if (bus_wr_file && (BUS_ADDR[FADDR_W-1:0] == FADDR_W'(gi)))
               file_mem[gi] <= BUS_WDATA;
         end
      end
   endgenerate

   // ==========================================================
   // return stack, pop wins over push; bottom entry repeats on pop
   generate
      for (gi = 0; gi < STACK_DEPTH; gi++)
      begin : g_stack
         always_ff @(posedge CLK)
         begin
            if (RESET)
               stack_r[gi] <= '0;
            else if (is_retlit)
            begin
               if (gi < STACK_DEPTH - 1)
                  stack_r[gi] <= stack_r[(gi + 1) % STACK_DEPTH];
            end
            else if (STACK_PUSH)
            begin
               if (gi == 0)
                  stack_r[gi] <= STACK_PUSH_ADDR;
               else
                  stack_r[gi] <= stack_r[(gi + STACK_DEPTH - 1) % STACK_DEPTH];
            end
         end
      end
   endgenerate

   // ==========================================================
   // program counter
   always_ff @(posedge CLK)
   begin
      if (RESET)
         pc_r <= '0;
      else if (is_retlit)
         pc_r <= stack_top;
      else if (take)
         pc_r <= pc_r + 1'b1;
   end

   // ==========================================================
   // sequencing
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         ST_EXEC:
         begin
            if (is_retlit)
               state_nxt = ST_FLUSH;
            else if (is_sleep)
               state_nxt = ST_SLEEP;
         end
         ST_FLUSH:
            state_nxt = ST_EXEC;
         ST_SLEEP:
         begin
            if (wake_evt)
               state_nxt = ST_EXEC;
         end
         default:
            state_nxt = ST_EXEC;
      endcase
   end

   always_ff @(posedge CLK)
   begin
      if (RESET)
         state_r <= ST_EXEC;
      else
         state_r <= state_nxt;
   end

   always_ff @(posedge CLK)
   begin
      if (RESET)
      begin
         ready_r    <= 1'b1;
         sleeping_r <= 1'b0;
         osc_en_r   <= 1'b1;
      end
      else
      begin
         ready_r    <= (state_nxt == ST_EXEC);
         sleeping_r <= (state_nxt == ST_SLEEP);
         osc_en_r   <= (state_nxt != ST_SLEEP);
      end
   end

   // ==========================================================
   // accumulator and option register
   always_ff @(posedge CLK)
   begin
      if (RESET)
         acc_r <= ACC_RST;
      else if (wr_acc_alu)
         acc_r <= alu_res;
      else if (is_loadlit || is_retlit)
         acc_r <= lit;
   end

   always_ff @(posedge CLK)
   begin
      if (RESET)
         option_r <= OPTION_RST;
      else if (is_option)
         option_r <= acc_r;
   end

   // ==========================================================
   // status flags
   always_ff @(posedge CLK)
   begin
      if (RESET)
         flags_r <= FLAGS_RST;
      else
      begin
         if (alu_op)
            flags_r.zero <= (alu_res == '0);
         if (is_sleep)
         begin
            flags_r.to <= 1'b1;
            flags_r.pd <= 1'b0;
         end
         else if (wdt_ovf)
            flags_r.to <= 1'b0;
         // pin wake sets, software clear loses in the same cycle
         if ((state_r == ST_SLEEP) && WAKE_PIN)
            flags_r.wake <= 1'b1;
         else if (wake_clear)
            flags_r.wake <= 1'b0;
      end
   end

   // ==========================================================
   // watchdog, keeps running in sleep so it can wake the core
   // sleep clears watchdog
   mise_watchdog #(
      .PRE_W (WDT_PRE_W),
      .CNT_W (WDT_CNT_W)
   ) u_wdt (
      .clk      (CLK),
      .reset    (RESET),
      .clear    (is_sleep),
      .count    (wdt_cnt),
      .prescale (wdt_pre),
      .overflow (wdt_ovf)
   );

   // ==========================================================
   // register port read
   always_ff @(posedge CLK)
   begin
      if (RESET || !BUS_RD)
         rd_data_r <= '0;
      else if (!BUS_ADDR[FILE_SEL_BIT])
         rd_data_r <= file_mem[BUS_ADDR[FADDR_W-1:0]];
      else
      begin
         unique case (BUS_ADDR)
            ADDR_ACC:    rd_data_r <= acc_r;
            ADDR_FLAGS:  rd_data_r <= DATA_W'(flags_r);
            ADDR_OPTION: rd_data_r <= option_r;
            ADDR_PC_LO:  rd_data_r <= pc_wide[DATA_W-1:0];
            ADDR_PC_HI:  rd_data_r <= pc_wide[2*DATA_W-1:DATA_W];
            ADDR_STATE:  rd_data_r <= DATA_W'(state_r);
            ADDR_WDT:    rd_data_r <= DATA_W'(wdt_cnt);
            default:     rd_data_r <= '0;
         endcase
      end
   end

   assign BUS_RDATA   = rd_data_r;
   assign INSTR_READY = ready_r;
   assign PC_OUT      = pc_r;
   assign ACC_OUT     = acc_r;
   assign OPTION_OUT  = option_r;
   assign FLAGS_OUT   = flags_r;
   assign SLEEPING    = sleeping_r;
   assign OSC_EN      = osc_en_r;

   // ==========================================================
   // checks
   or_result_a: assert property (@(posedge CLK) disable iff (RESET)
      (is_or && dest == DEST_ACC) |=>
         (ACC_OUT == ($past(acc_r) | $past(file_rd))) && (FLAGS_OUT.zero == (ACC_OUT == '0)))
      else $error("or result or zero wrong");
   dest_file_a: assert property (@(posedge CLK) disable iff (RESET)
      wr_file |=> file_mem[$past(f_addr)] == $past(wr_data))
      else $error("file destination not written");
   dest_acc_a: assert property (@(posedge CLK) disable iff (RESET)
      (alu_op && dest == DEST_FILE) |=> ACC_OUT == $past(acc_r))
      else $error("accumulator changed on file destination");
   store_flags_a: assert property (@(posedge CLK) disable iff (RESET)
      is_store |=> (file_mem[$past(f_addr)] == $past(acc_r)) && $stable(FLAGS_OUT.zero))
      else $error("store wrong or zero changed");
   copy_zero_a: assert property (@(posedge CLK) disable iff (RESET)
      is_copy |=> FLAGS_OUT.zero == ($past(file_rd) == '0))
      else $error("copy zero flag wrong");
   load_lit_a: assert property (@(posedge CLK) disable iff (RESET)
      is_loadlit |=> (ACC_OUT == $past(lit)) && $stable(FLAGS_OUT.zero))
      else $error("literal load wrong");
   option_load_a: assert property (@(posedge CLK) disable iff (RESET)
      is_option |=> (OPTION_OUT == $past(acc_r)) && $stable(ACC_OUT))
      else $error("option load wrong");
   ret_two_cycle_a: assert property (@(posedge CLK) disable iff (RESET)
      is_retlit |=> (PC_OUT == $past(stack_top)) && (ACC_OUT == $past(lit)) && !INSTR_READY
         ##1 INSTR_READY && (state_r == ST_EXEC))
      else $error("return with literal wrong");
   sleep_wdt_a: assert property (@(posedge CLK) disable iff (RESET)
      is_sleep |=> (wdt_cnt == '0) && (wdt_pre == '0))
      else $error("watchdog not cleared by sleep");
   sleep_flags_a: assert property (@(posedge CLK) disable iff (RESET)
      (is_sleep && !wake_clear) |=>
         FLAGS_OUT.to && !FLAGS_OUT.pd && (FLAGS_OUT.wake == $past(flags_r.wake)))
      else $error("sleep flag effects wrong");
   sleep_halt_a: assert property (@(posedge CLK) disable iff (RESET)
      is_sleep |=> SLEEPING && !OSC_EN && !INSTR_READY)
      else $error("sleep not entered");
   sleep_hold_a: assert property (@(posedge CLK) disable iff (RESET)
      (state_r == ST_SLEEP && !wake_evt) |=> SLEEPING && $stable(PC_OUT))
      else $error("left sleep without wake");
   zero_flag_a: assert property (@(posedge CLK) disable iff (RESET)
      alu_op |=> FLAGS_OUT.zero == ($past(alu_res) == '0))
      else $error("zero flag mismatch");
   nop_advance_a: assert property (@(posedge CLK) disable iff (RESET)
      is_nop |=> (PC_OUT == $past(pc_r) + 1'b1) && $stable(ACC_OUT) && $stable(FLAGS_OUT.zero))
      else $error("nop changed state");

endmodule

// >>> rtl/mise_pkg.sv
package mise_pkg;

   // ==========================================================
   // widths and sizes
   localparam int INSTR_W    = 12;
   localparam int DATA_W     = 8;
   localparam int FADDR_W    = 5;
   localparam int FILE_DEPTH = 32;
   localparam int DEST_BIT   = 5;
   localparam int BUS_AW     = 6;
   localparam int FILE_SEL_BIT = 5;

   // ==========================================================
   // instruction encodings, mask then value
   localparam logic [INSTR_W-1:0] OP_OR_MASK     = 12'hfc0;
   localparam logic [INSTR_W-1:0] OP_OR_VAL      = 12'h100;
   localparam logic [INSTR_W-1:0] OP_STORE_MASK  = 12'hfe0;
   localparam logic [INSTR_W-1:0] OP_STORE_VAL   = 12'h020;
   localparam logic [INSTR_W-1:0] OP_COPY_MASK   = 12'hfc0;
   localparam logic [INSTR_W-1:0] OP_COPY_VAL    = 12'h200;
   localparam logic [INSTR_W-1:0] OP_LIT_MASK    = 12'hf00;
   localparam logic [INSTR_W-1:0] OP_LOADLIT_VAL = 12'hc00;
   localparam logic [INSTR_W-1:0] OP_RETLIT_VAL  = 12'h800;
   localparam logic [INSTR_W-1:0] OP_NOP_VAL     = 12'h000;
   localparam logic [INSTR_W-1:0] OP_OPTION_VAL  = 12'h002;
   localparam logic [INSTR_W-1:0] OP_SLEEP_VAL   = 12'h003;

   localparam logic DEST_ACC  = 1'b0;
   localparam logic DEST_FILE = 1'b1;

   // ==========================================================
   // register port map, addresses below 6'h20 reach the file array
   localparam logic [BUS_AW-1:0] ADDR_ACC     = 6'h20;
   localparam logic [BUS_AW-1:0] ADDR_FLAGS   = 6'h21;
   localparam logic [BUS_AW-1:0] ADDR_OPTION  = 6'h22;
   localparam logic [BUS_AW-1:0] ADDR_PC_LO   = 6'h23;
   localparam logic [BUS_AW-1:0] ADDR_PC_HI   = 6'h24;
   localparam logic [BUS_AW-1:0] ADDR_STATE   = 6'h25;
   localparam logic [BUS_AW-1:0] ADDR_WDT     = 6'h26;

   localparam int FLAG_WAKE_BIT = 3;

   // ==========================================================
   // reset values
   localparam logic [DATA_W-1:0] OPTION_RST = 8'hff;
   localparam logic [DATA_W-1:0] ACC_RST    = 8'h00;
   localparam logic [DATA_W-1:0] FILE_RST   = 8'h00;

   typedef struct packed {
      logic wake;
      logic pd;
      logic to;
      logic zero;
   } mise_flags_s;

   localparam mise_flags_s FLAGS_RST = '{wake: 1'b0, pd: 1'b1, to: 1'b1, zero: 1'b0};

   typedef enum logic [2:0] {
      ST_EXEC  = 3'b001,
      ST_FLUSH = 3'b010,
      ST_SLEEP = 3'b100
   } mise_state_e;

endpackage

// >>> rtl/mise_watchdog.sv
`timescale 1ns/100ps

module mise_watchdog
   import mise_pkg::*;
#(
   parameter int PRE_W = 8,
   parameter int CNT_W = 8
)
(
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic             clear,
   output logic      [CNT_W-1:0] count,
   output logic      [PRE_W-1:0] prescale,
   output logic                  overflow
);

   logic [PRE_W-1:0] pre_r;
   logic [CNT_W-1:0] cnt_r;
   logic             ovf_r;
   logic             pre_wrap;

   generate
      if (PRE_W < 1 || CNT_W < 1 || CNT_W > DATA_W)
      begin : g_bad
         $error("watchdog widths out of range");
      end
   endgenerate

   assign pre_wrap = (pre_r == '1);

   // ==========================================================
   // prescaler and counter, clear wins over counting
   always_ff @(posedge clk)
   begin
      if (reset || clear)
      begin
         pre_r <= '0;
         cnt_r <= '0;
      end
      else
      begin
         pre_r <= pre_r + 1'b1;
         if (pre_wrap)
            cnt_r <= cnt_r + 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset || clear)
         ovf_r <= 1'b0;
      else
         ovf_r <= pre_wrap && (cnt_r == '1);
   end

   assign count    = cnt_r;
   assign prescale = pre_r;
   assign overflow = ovf_r;

endmodule

// >>> sim/testbench.sv
`timescale 1ns/100ps

module testbench
   import mise_pkg::*;
();

   localparam int PC_W = 9;

   typedef struct packed
   {
      logic [INSTR_W-1:0] instr;
      logic [DATA_W-1:0]  acc;
      logic               zero;
      logic [DATA_W-1:0]  opt;
   } mise_row_s;

   logic                clk = 1'b0;
   logic                reset = 1'b1;
   logic [INSTR_W-1:0]  instr = '0;
   logic                instr_valid = 1'b0;
   logic                wake_pin = 1'b0;
   logic                stack_push = 1'b0;
   logic [PC_W-1:0]     stack_push_addr = '0;
   logic [BUS_AW-1:0]   bus_addr = '0;
   logic [DATA_W-1:0]   bus_wdata = '0;
   logic                bus_wr = 1'b0;
   logic                bus_rd = 1'b0;
   logic [DATA_W-1:0]   bus_rdata;
   logic                instr_ready;
   logic [PC_W-1:0]     pc_out;
   logic [DATA_W-1:0]   acc_out;
   logic [DATA_W-1:0]   option_out;
   mise_flags_s         flags_out;
   logic                sleeping;
   logic                osc_en;
   int                  n_errors = 0;
   int                  check_count = 0;
   int                  cycles = 0;
   logic [DATA_W-1:0]   rd;
   mise_row_s           rows [0:12];

   // shortened watchdog, overflow after 256 cycles; awake phases stay shorter than that
   mise_core #(.PC_W(PC_W), .STACK_DEPTH(2), .WDT_PRE_W(4), .WDT_CNT_W(4)) i_mise_core
   (
      .CLK             (clk),
      .RESET           (reset),
      .INSTR           (instr),
      .INSTR_VALID     (instr_valid),
      .WAKE_PIN        (wake_pin),
      .STACK_PUSH      (stack_push),
      .STACK_PUSH_ADDR (stack_push_addr),
      .BUS_ADDR        (bus_addr),
      .BUS_WDATA       (bus_wdata),
      .BUS_WR          (bus_wr),
      .BUS_RD          (bus_rd),
      .BUS_RDATA       (bus_rdata),
      .INSTR_READY     (instr_ready),
      .PC_OUT          (pc_out),
      .ACC_OUT         (acc_out),
      .OPTION_OUT      (option_out),
      .FLAGS_OUT       (flags_out),
      .SLEEPING        (sleeping),
      .OSC_EN          (osc_en)
   );

   // ==========================================================
   // clock, timeout and shared tasks
   always #50 clk = ~clk;

   task automatic finish_test();
      if (n_errors == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         n_errors++;
         finish_test();
      end
   end

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   // the taking edge also lowers valid, so each instruction is taken once
   task automatic exec(input logic [INSTR_W-1:0] op);
      @(posedge clk);
      instr <= op;
      instr_valid <= 1'b1;
      @(posedge clk);
      instr_valid <= 1'b0;
      @(negedge clk);
   endtask

   task automatic bus_write(input logic [BUS_AW-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge clk);
      bus_wr <= 1'b0;
   endtask

   task automatic bus_read(input logic [BUS_AW-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clk);
      bus_rd <= 1'b0;
      @(negedge clk);
      d = bus_rdata;
   endtask

   // ==========================================================
   // main sequence
   initial
   begin
      rows = '{
         '{12'hc00, 8'h00, 1'b0, 8'hff}, '{12'hca5, 8'ha5, 1'b0, 8'hff},
         '{12'h023, 8'ha5, 1'b0, 8'hff}, '{12'hc00, 8'h00, 1'b0, 8'hff},
         '{12'h203, 8'ha5, 1'b0, 8'hff}, '{12'h224, 8'ha5, 1'b1, 8'hff},
         '{12'hc5a, 8'h5a, 1'b1, 8'hff}, '{12'h123, 8'h5a, 1'b0, 8'hff},
         '{12'h104, 8'h5a, 1'b0, 8'hff}, '{12'hc00, 8'h00, 1'b0, 8'hff},
         '{12'h104, 8'h00, 1'b1, 8'hff}, '{12'h002, 8'h00, 1'b1, 8'h00},
         '{12'h000, 8'h00, 1'b1, 8'h00}};
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      @(negedge clk);
      chk("pc", 16'h0000, 16'(pc_out));
      chk("acc", 16'h0000, 16'(acc_out));
      chk("option", 16'h00ff, 16'(option_out));
      chk("flags", 16'h0006, 16'(flags_out));
      chk("run", 16'h0003, 16'({sleeping, osc_en, instr_ready}));

      for (int i = 0; i < 13; i++)
      begin
         exec(rows[i].instr);
         chk("acc", 16'(rows[i].acc), 16'(acc_out)); // result
         chk("zero", 16'(rows[i].zero), 16'(flags_out.zero)); // flag
         chk("option", 16'(rows[i].opt), 16'(option_out)); // option load
         chk("pc", 16'(i + 1), 16'(pc_out)); // counter advance
      end
      bus_read(6'h03, rd);
      chk("file3", 16'h00ff, 16'(rd)); // file destination
      bus_read(6'h04, rd);
      chk("file4", 16'h0000, 16'(rd)); // copy onto itself

      // return pops the pushed address and stalls one cycle
      @(posedge clk);
      stack_push <= 1'b1;
      stack_push_addr <= 9'h1a5;
      @(posedge clk);
      stack_push <= 1'b0;
      exec(12'h8c3);
      chk("pc", 16'h01a5, 16'(pc_out)); // stack pop
      chk("acc", 16'h00c3, 16'(acc_out)); // literal load
      chk("flags", 16'h0007, 16'(flags_out)); // flags kept
      chk("ready", 16'h0000, 16'(instr_ready)); // second cycle
      @(negedge clk);
      chk("ready", 16'h0001, 16'(instr_ready)); // two cycles
      bus_read(ADDR_PC_LO, rd);
      chk("pc_lo", 16'h00a5, 16'(rd)); // return address
      bus_read(ADDR_PC_HI, rd);
      chk("pc_hi", 16'h0001, 16'(rd)); // return address

      bus_read(6'h3f, rd);
      chk("unmapped", 16'h0000, 16'(rd));
      bus_write(ADDR_ACC, 8'h77);
      @(negedge clk);
      chk("acc", 16'h00c3, 16'(acc_out));

      // sleep, a refused instruction, then wake by pin
      exec(OP_SLEEP_VAL);
      chk("run", 16'h0004, 16'({sleeping, osc_en, instr_ready})); // halted
      chk("flags", 16'h0003, 16'(flags_out)); // timeout and powerdown
      chk("pc", 16'h01a6, 16'(pc_out));
      bus_read(ADDR_WDT, rd);
      chk("wdt", 16'h0000, 16'(rd)); // watchdog cleared
      bus_read(ADDR_STATE, rd);
      chk("state", 16'h0004, 16'(rd)); // sleep state
      exec(12'hc11);
      chk("acc", 16'h00c3, 16'(acc_out)); // no execution asleep
      @(posedge clk);
      wake_pin <= 1'b1;
      @(posedge clk);
      wake_pin <= 1'b0;
      for (int k = 0; k < 3 && sleeping !== 1'b0; k++)
         @(negedge clk);
      chk("run", 16'h0003, 16'({sleeping, osc_en, instr_ready})); // wake
      chk("wake", 16'h0001, 16'(flags_out.wake));

      // sleep again with the wake flag up, left to the watchdog
      exec(OP_SLEEP_VAL);
      chk("wake", 16'h0001, 16'(flags_out.wake)); // wake flag kept
      for (int k = 0; k < 300 && sleeping !== 1'b0; k++)
         @(negedge clk);
      chk("osc", 16'h0001, 16'(osc_en)); // oscillator back on after wake
      chk("timeout", 16'h0000, 16'(flags_out.to));
      chk("pd", 16'h0000, 16'(flags_out.pd)); // powerdown held

      // third sleep raises timeout again; the port still answers asleep
      exec(OP_SLEEP_VAL);
      chk("timeout", 16'h0001, 16'(flags_out.to)); // timeout set
      bus_write(ADDR_FLAGS, 8'h08);
      bus_read(ADDR_FLAGS, rd);
      chk("wake_pd", 16'h0000, 16'(rd[3:2]));
      finish_test();
   end

endmodule
